// >>> inc/vdta_pkg.sv
// Purpose: Shared constants for the VLAN read word and priority table access block.
// Assumes: Registers are addressed by their 16-bit register number.
// Notes: All field positions, reset values and register numbers live here.

package vdta_pkg;

  // ----------------------------------------------------------------
  // Register numbers
  // ----------------------------------------------------------------
  localparam int IDX_W = 16;
  localparam logic [15:0] VLAN_RD_WORD_IDX = 16'h180e;
  localparam logic [15:0] VLAN_STATUS_IDX = 16'h1810;
  localparam logic [15:0] PT_CMD_IDX = 16'h1811;
  localparam logic [15:0] PT_WR_IDX = 16'h1812;
  localparam logic [15:0] PT_RD_IDX = 16'h1813;
  localparam logic [15:0] PT_STATUS_IDX = 16'h1814;

  // ----------------------------------------------------------------
  // Field layouts
  // ----------------------------------------------------------------
  localparam int DATA_W = 32;
  localparam int PORTS = 3;
  localparam int VID_W = 12;
  localparam int PVID_W = 18;
  localparam int UNTAG0_BIT = 12;
  localparam int MEMBER0_BIT = 13;
  localparam int PORT_STRIDE = 2;
  localparam int PENDING_BIT = 0;
  localparam int DIR_BIT = 7;
  localparam int INDEX_W = 6;
  localparam int PRIO_W = 3;
  localparam int TABLE_DEPTH = 64;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [DATA_W-1:0] WORD_RESET = 32'h0000_0000;
  localparam logic [PRIO_W-1:0] PRIO_RESET = 3'h0;
  localparam logic [INDEX_W-1:0] INDEX_RESET = 6'h00;
  localparam logic [PORTS-1:0] PORTS_RESET = 3'h0;

  // Priority table command sequencer states.
  typedef enum logic [1:0] {DS_IDLE, DS_ACCESS, DS_CAPTURE} vdta_ds_state_e;

endpackage : vdta_pkg

// >>> inc/vdta_mem_if.sv
// Purpose: Carrier between the access logic and the priority table memory.
// Assumes: Both ends run on core_clk.
// Notes: The command port is used by software commands, the lookup port by ingress.

`timescale 1ns/1ns

interface vdta_mem_if;
  logic cmdEn;
  logic cmdWrite;
  logic [vdta_pkg::INDEX_W-1:0] cmdIndex;
  logic [vdta_pkg::PRIO_W-1:0] cmdWdata;
  logic [vdta_pkg::PRIO_W-1:0] cmdRdata;
  logic [vdta_pkg::INDEX_W-1:0] lookIndex;
  logic [vdta_pkg::PRIO_W-1:0] lookData;

  modport user (
    output cmdEn,
    output cmdWrite,
    output cmdIndex,
    output cmdWdata,
    output lookIndex,
    input cmdRdata,
    input lookData
  );

  modport mem (
    input cmdEn,
    input cmdWrite,
    input cmdIndex,
    input cmdWdata,
    input lookIndex,
    output cmdRdata,
    output lookData
  );
endinterface : vdta_mem_if

// >>> verilog/vdta_prio_mem.sv
// Purpose: Sixty-four entry receive priority table with registered read data.
// Assumes: One command access and one lookup per cycle at most.
// Notes: The table contents are not reset; only the read registers are.

`timescale 1ns/1ns

module vdta_prio_mem (
  input wire logic core_clk,
  input wire logic arst_n,
  vdta_mem_if.mem bus
);

  logic [vdta_pkg::PRIO_W-1:0] table_q [vdta_pkg::TABLE_DEPTH];
  logic [vdta_pkg::PRIO_W-1:0] cmdRdata_q;
  logic [vdta_pkg::PRIO_W-1:0] cmdRdata_d;
  logic [vdta_pkg::PRIO_W-1:0] lookData_q;
  logic [vdta_pkg::PRIO_W-1:0] lookData_d;

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  // Entries are written only by a write command, so they stay undefined until software fills them.
  always_ff @(posedge core_clk) begin
    if (bus.cmdEn && bus.cmdWrite) begin
      table_q[bus.cmdIndex] <= bus.cmdWdata;
    end
  end

  // Command reads load only on a read access; lookups load every cycle.
  always_comb begin
    cmdRdata_d = cmdRdata_q;
    if (bus.cmdEn && !bus.cmdWrite) begin
      cmdRdata_d = table_q[bus.cmdIndex];
    end
    lookData_d = table_q[bus.lookIndex];
  end

  // Read data registers.
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      cmdRdata_q <= vdta_pkg::PRIO_RESET;
      lookData_q <= vdta_pkg::PRIO_RESET;
    end else begin
      cmdRdata_q <= cmdRdata_d;
      lookData_q <= lookData_d;
    end
  end

  assign bus.cmdRdata = cmdRdata_q;
  assign bus.lookData = lookData_q;

endmodule : vdta_prio_mem

// >>> verilog/vdta_table_access.sv
// Purpose: VLAN read word formatting, VLAN command tracking and priority table access.
// Assumes: Register requests and table side signals come from logic on core_clk.
// Notes: Register reads answer one cycle after the read strobe.

`timescale 1ns/1ns

module vdta_table_access (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic [vdta_pkg::IDX_W-1:0] regIdx,
  input wire logic regWrEn,
  input wire logic regRdEn,
  input wire logic [vdta_pkg::DATA_W-1:0] regWdata,
  output logic [vdta_pkg::DATA_W-1:0] regRdata,
  output logic regRvalid,
  input wire logic vlanCmdStart,
  input wire logic vlanCmdRead,
  input wire logic tableSelect,
  output logic vlanTblReq,
  output logic vlanTblReqRead,
  input wire logic vlanTblAck,
  input wire logic [vdta_pkg::PORTS-1:0] vlanEntMember,
  input wire logic [vdta_pkg::PORTS-1:0] vlanEntUntag,
  input wire logic [vdta_pkg::VID_W-1:0] vlanEntVid,
  input wire logic [vdta_pkg::PVID_W-1:0] pvidWord,
  input wire logic [vdta_pkg::PORTS-1:0] matchMember,
  input wire logic [vdta_pkg::PORTS-1:0] matchUntag,
  input wire logic [vdta_pkg::PORTS-1:0] admitOutsider,
  input wire logic [vdta_pkg::PORTS-1:0] egressHybrid,
  output logic [vdta_pkg::PORTS-1:0] portAdmit,
  output logic [vdta_pkg::PORTS-1:0] egressMember,
  output logic [vdta_pkg::PORTS-1:0] tagStrip,
  input wire logic [vdta_pkg::INDEX_W-1:0] tosIndex,
  output logic [vdta_pkg::PRIO_W-1:0] rxPriority
);

  // ----------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------
  // Builds the VLAN table read word from one entry's fields.
  function automatic logic [vdta_pkg::DATA_W-1:0] packVlanWord(
    input logic [vdta_pkg::PORTS-1:0] member,
    input logic [vdta_pkg::PORTS-1:0] untag,
    input logic [vdta_pkg::VID_W-1:0] vid
  );
    logic [vdta_pkg::DATA_W-1:0] w;
    w = vdta_pkg::WORD_RESET;
    w[vdta_pkg::VID_W-1:0] = vid;
    for (int p = 0; p < vdta_pkg::PORTS; p++) begin
      w[vdta_pkg::MEMBER0_BIT + vdta_pkg::PORT_STRIDE * p] = member[p];
      w[vdta_pkg::UNTAG0_BIT + vdta_pkg::PORT_STRIDE * p] = untag[p];
    end
    return w;
  endfunction : packVlanWord

  // Tells whether a register request targets the given register number.
  function automatic logic hits(
    input logic [vdta_pkg::IDX_W-1:0] idx,
    input logic [vdta_pkg::IDX_W-1:0] target
  );
    return idx == target;
  endfunction : hits

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic vlanPending_q;
  logic vlanPending_d;
  logic vlanRead_q;
  logic vlanRead_d;
  logic vlanSel_q;
  logic vlanSel_d;
  logic vlanReq_q;
  logic vlanReq_d;
  logic [vdta_pkg::DATA_W-1:0] vlanWord_q;
  logic [vdta_pkg::DATA_W-1:0] vlanWord_d;
  vdta_pkg::vdta_ds_state_e dsState_q;
  vdta_pkg::vdta_ds_state_e dsState_d;
  logic dsPending_q;
  logic dsPending_d;
  logic dsDir_q;
  logic dsDir_d;
  logic [vdta_pkg::INDEX_W-1:0] dsIndex_q;
  logic [vdta_pkg::INDEX_W-1:0] dsIndex_d;
  logic [vdta_pkg::PRIO_W-1:0] dsWr_q;
  logic [vdta_pkg::PRIO_W-1:0] dsWr_d;
  logic [vdta_pkg::PRIO_W-1:0] dsRd_q;
  logic [vdta_pkg::PRIO_W-1:0] dsRd_d;
  logic [vdta_pkg::DATA_W-1:0] rdata_q;
  logic [vdta_pkg::DATA_W-1:0] rdata_d;
  logic rvalid_q;
  logic rvalid_d;
  logic [vdta_pkg::PORTS-1:0] admit_q;
  logic [vdta_pkg::PORTS-1:0] admit_d;
  logic [vdta_pkg::PORTS-1:0] egress_q;
  logic [vdta_pkg::PORTS-1:0] egress_d;
  logic [vdta_pkg::PORTS-1:0] strip_q;
  logic [vdta_pkg::PORTS-1:0] strip_d;
  logic dsAccept;

  vdta_mem_if memIf ();

  vdta_prio_mem u_mem (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .bus(memIf)
  );

  // ----------------------------------------------------------------
  // VLAN command tracking
  // ----------------------------------------------------------------
  // A start is taken only when idle; the ack clears pending and, for a read command, loads the read word.
  always_comb begin
    vlanPending_d = vlanPending_q;
    vlanRead_d = vlanRead_q;
    vlanSel_d = vlanSel_q;
    vlanReq_d = 1'b0;
    vlanWord_d = vlanWord_q;
    if (!vlanPending_q && vlanCmdStart) begin
      vlanPending_d = 1'b1;
      vlanRead_d = vlanCmdRead;
      vlanSel_d = tableSelect;
      vlanReq_d = 1'b1;
    end else if (vlanPending_q && vlanTblAck) begin
      vlanPending_d = 1'b0;
      if (vlanRead_q) begin
        if (vlanSel_q) begin
          vlanWord_d = vdta_pkg::DATA_W'(pvidWord);
        end else begin
          vlanWord_d = packVlanWord(vlanEntMember, vlanEntUntag, vlanEntVid);
        end
      end
    end
  end

  // VLAN command registers; starts during pending never reach here.
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      vlanPending_q <= 1'b0;
      vlanRead_q <= 1'b0;
      vlanSel_q <= 1'b0;
      vlanReq_q <= 1'b0;
      vlanWord_q <= vdta_pkg::WORD_RESET;
    end else begin
      vlanPending_q <= vlanPending_d;
      vlanRead_q <= vlanRead_d;
      vlanSel_q <= vlanSel_d;
      vlanReq_q <= vlanReq_d;
      vlanWord_q <= vlanWord_d;
    end
  end

  // ----------------------------------------------------------------
  // Priority table command sequencer
  // ----------------------------------------------------------------
  assign dsAccept = regWrEn && hits(regIdx, vdta_pkg::PT_CMD_IDX) && !dsPending_q;

  // Idle takes a command, access drives the table, capture loads read data.
  always_comb begin
    dsState_d = dsState_q;
    dsDir_d = dsDir_q;
    dsIndex_d = dsIndex_q;
    dsRd_d = dsRd_q;
    dsWr_d = dsWr_q;
    if (regWrEn && hits(regIdx, vdta_pkg::PT_WR_IDX)) begin
      dsWr_d = regWdata[vdta_pkg::PRIO_W-1:0];
    end
    case (dsState_q)
      vdta_pkg::DS_IDLE: begin
        if (dsAccept) begin
          dsDir_d = regWdata[vdta_pkg::DIR_BIT];
          dsIndex_d = regWdata[vdta_pkg::INDEX_W-1:0];
          dsState_d = vdta_pkg::DS_ACCESS;
        end
      end
      vdta_pkg::DS_ACCESS: begin
        dsState_d = vdta_pkg::DS_CAPTURE;
      end
      vdta_pkg::DS_CAPTURE: begin
        if (dsDir_q) begin
          dsRd_d = memIf.cmdRdata;
        end
        dsState_d = vdta_pkg::DS_IDLE;
      end
      default: begin
        dsState_d = vdta_pkg::DS_IDLE;
      end
    endcase
    dsPending_d = dsState_d != vdta_pkg::DS_IDLE;
  end

  // Sequencer registers.
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      dsState_q <= vdta_pkg::DS_IDLE;
      dsPending_q <= 1'b0;
      dsDir_q <= 1'b0;
      dsIndex_q <= vdta_pkg::INDEX_RESET;
      dsWr_q <= vdta_pkg::PRIO_RESET;
      dsRd_q <= vdta_pkg::PRIO_RESET;
    end else begin
      dsState_q <= dsState_d;
      dsPending_q <= dsPending_d;
      dsDir_q <= dsDir_d;
      dsIndex_q <= dsIndex_d;
      dsWr_q <= dsWr_d;
      dsRd_q <= dsRd_d;
    end
  end

  // Table ports: one command access in the access state, lookup every cycle.
  assign memIf.cmdEn = dsState_q == vdta_pkg::DS_ACCESS;
  assign memIf.cmdWrite = !dsDir_q;
  assign memIf.cmdIndex = dsIndex_q;
  assign memIf.cmdWdata = dsWr_q;
  assign memIf.lookIndex = tosIndex;

  // ----------------------------------------------------------------
  // Register read port
  // ----------------------------------------------------------------
  // Read mux; reserved and unmapped bits read zero.
  always_comb begin
    rvalid_d = regRdEn;
    rdata_d = rdata_q;
    if (regRdEn) begin
      case (regIdx)
        vdta_pkg::VLAN_RD_WORD_IDX: rdata_d = vlanWord_q;
        vdta_pkg::VLAN_STATUS_IDX: rdata_d = vdta_pkg::DATA_W'(vlanPending_q);
        vdta_pkg::PT_CMD_IDX: rdata_d = vdta_pkg::DATA_W'({dsDir_q, 1'b0, dsIndex_q});
        vdta_pkg::PT_WR_IDX: rdata_d = vdta_pkg::DATA_W'(dsWr_q);
        vdta_pkg::PT_RD_IDX: rdata_d = vdta_pkg::DATA_W'(dsRd_q);
        vdta_pkg::PT_STATUS_IDX: rdata_d = vdta_pkg::DATA_W'(dsPending_q);
        default: rdata_d = vdta_pkg::WORD_RESET;
      endcase
    end
  end

  // Read answer registers.
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      rdata_q <= vdta_pkg::WORD_RESET;
      rvalid_q <= 1'b0;
    end else begin
      rdata_q <= rdata_d;
      rvalid_q <= rvalid_d;
    end
  end

  // ----------------------------------------------------------------
  // Per-port forwarding decisions
  // ----------------------------------------------------------------
  // Membership or admitOutsider gates ingress, membership alone the broadcast domain; untag strips only on hybrid ports.
  always_comb begin
    admit_d = matchMember | admitOutsider;
    egress_d = matchMember;
    strip_d = matchUntag & egressHybrid;
  end

  // Decision registers.
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      admit_q <= vdta_pkg::PORTS_RESET;
      egress_q <= vdta_pkg::PORTS_RESET;
      strip_q <= vdta_pkg::PORTS_RESET;
    end else begin
      admit_q <= admit_d;
      egress_q <= egress_d;
      strip_q <= strip_d;
    end
  end

  // Outputs, each from a register.
  assign regRdata = rdata_q;
  assign regRvalid = rvalid_q;
  assign vlanTblReq = vlanReq_q;
  assign vlanTblReqRead = vlanRead_q;
  assign portAdmit = admit_q;
  assign egressMember = egress_q;
  assign tagStrip = strip_q;
  assign rxPriority = memIf.lookData;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);

  a_vlan_pend_rise: assert property (vlanCmdStart && !vlanPending_q
    |=> vlanPending_q && vlanTblReq) else $error("VLAN pending did not rise after start.");
  a_vlan_pend_clear: assert property (vlanPending_q && vlanTblAck |=> !vlanPending_q)
    else $error("VLAN pending did not clear on ack.");
  a_vlan_cmd_hold: assert property (vlanPending_q && !vlanTblAck |=> vlanPending_q
    && $stable(vlanSel_q) && $stable(vlanRead_q)) else $error("Pending command moved.");
  a_vlan_word_format: assert property (vlanPending_q && vlanTblAck && vlanRead_q
    && !vlanSel_q |=> vlanWord_q[vdta_pkg::VID_W-1:0] == $past(vlanEntVid)
    && vlanWord_q[vdta_pkg::MEMBER0_BIT] == $past(vlanEntMember[0])) else $error("Bad VLAN word.");
  a_ds_pend_span: assert property (dsAccept |=> dsPending_q [*2] ##1 !dsPending_q)
    else $error("Priority command pending span wrong.");
  a_ds_dir_decode: assert property (dsAccept |=> memIf.cmdEn
    && memIf.cmdWrite == !$past(regWdata[vdta_pkg::DIR_BIT])) else $error("Bad direction.");
  a_ds_index_use: assert property (dsAccept
    |=> memIf.cmdIndex == $past(regWdata[vdta_pkg::INDEX_W-1:0])) else $error("Bad index.");
  a_ds_cmd_ignore: assert property (dsPending_q && regWrEn
    && hits(regIdx, vdta_pkg::PT_CMD_IDX) |=> $stable(dsIndex_q) && $stable(dsDir_q))
    else $error("Command accepted while pending.");
  a_ds_read_capture: assert property (dsState_q == vdta_pkg::DS_CAPTURE && dsDir_q
    |=> dsRd_q == $past(memIf.cmdRdata) && !dsPending_q) else $error("Read not captured.");
  a_ds_status_read: assert property (regRdEn && hits(regIdx, vdta_pkg::PT_STATUS_IDX) |=>
    regRvalid && regRdata[vdta_pkg::PENDING_BIT] == $past(dsPending_q)) else $error("Bad status.");
  a_port_strip: assert property (##1 tagStrip == $past(matchUntag & egressHybrid)
    && portAdmit == $past(matchMember | admitOutsider)) else $error("Bad forwarding decision.");

  c_vlan_read: cover property (vlanCmdStart && vlanCmdRead && !vlanPending_q ##[1:20] vlanTblAck);
  c_ds_read: cover property (dsAccept && regWdata[vdta_pkg::DIR_BIT] ##3 !dsPending_q);
  c_ds_write: cover property (dsAccept && !regWdata[vdta_pkg::DIR_BIT]);
  c_ds_ignored: cover property (dsPending_q && regWrEn && hits(regIdx, vdta_pkg::PT_CMD_IDX));

endmodule : vdta_table_access

// >>> testbench/vdta_table_access_tb_top.sv
// Purpose: Self-checking bench for the VLAN read word and priority table access block.
// Assumes: Register reads answer one cycle after the strobe; priority commands pend 2 cycles.
// Notes: All inputs change at rising edges by non-blocking assignment; checks at falling edges, except the two reset checks at a rising edge.

`timescale 1ns/1ns

module vdta_table_access_tb_top;
  logic core_clk = 1'b0;
  logic arst_n = 1'b0;
  logic [15:0] regIdx = 16'h0000;
  logic regWrEn = 1'b0;
  logic regRdEn = 1'b0;
  logic [31:0] regWdata = 32'h0000_0000;
  logic [31:0] regRdata;
  logic regRvalid;
  logic vlanCmdStart = 1'b0;
  logic vlanCmdRead = 1'b0;
  logic tableSelect = 1'b0;
  logic vlanTblReq;
  logic vlanTblReqRead;
  logic vlanTblAck = 1'b0;
  logic [2:0] vlanEntMember = 3'h0;
  logic [2:0] vlanEntUntag = 3'h0;
  logic [11:0] vlanEntVid = 12'h000;
  logic [17:0] pvidWord = 18'h0_0000;
  logic [2:0] matchMember = 3'h0;
  logic [2:0] matchUntag = 3'h0;
  logic [2:0] admitOutsider = 3'h0;
  logic [2:0] egressHybrid = 3'h0;
  logic [2:0] portAdmit;
  logic [2:0] egressMember;
  logic [2:0] tagStrip;
  logic [5:0] tosIndex = 6'h00;
  logic [2:0] rxPriority;
  logic [31:0] rdVal;
  int error_cnt = 0;
  int tests_run = 0;

  // ----------------------------------------------------------------
  // Clock and device under test
  // ----------------------------------------------------------------
  // The clock toggles every half period of 10 ns.
  always #10 core_clk = ~core_clk;

  vdta_table_access vdta_table_access_i (
    .core_clk(core_clk), .arst_n(arst_n), .regIdx(regIdx), .regWrEn(regWrEn),
    .regRdEn(regRdEn), .regWdata(regWdata), .regRdata(regRdata), .regRvalid(regRvalid),
    .vlanCmdStart(vlanCmdStart), .vlanCmdRead(vlanCmdRead), .tableSelect(tableSelect),
    .vlanTblReq(vlanTblReq), .vlanTblReqRead(vlanTblReqRead), .vlanTblAck(vlanTblAck),
    .vlanEntMember(vlanEntMember), .vlanEntUntag(vlanEntUntag), .vlanEntVid(vlanEntVid),
    .pvidWord(pvidWord), .matchMember(matchMember), .matchUntag(matchUntag),
    .admitOutsider(admitOutsider), .egressHybrid(egressHybrid), .portAdmit(portAdmit),
    .egressMember(egressMember), .tagStrip(tagStrip), .tosIndex(tosIndex),
    .rxPriority(rxPriority)
  );

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  // Compares with case equality so that an unknown never matches.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk

  // Prints the counts and the verdict, then stops the run.
  task automatic test_done();
    $display("Comparisons %0d, mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : test_done

  // Writes one register; leaves a quiet cycle so the strobe is never re-driven at once.
  task automatic reg_wr(input logic [15:0] idx, input logic [31:0] data);
    regWrEn <= 1'b1;
    regIdx <= idx;
    regWdata <= data;
    @(posedge core_clk);
    regWrEn <= 1'b0;
    @(posedge core_clk);
  endtask : reg_wr

  // Reads one register into rdVal and checks that the answer is marked valid.
  task automatic reg_rd(input logic [15:0] idx);
    regRdEn <= 1'b1;
    regIdx <= idx;
    @(posedge core_clk);
    regRdEn <= 1'b0;
    @(negedge core_clk);
    chk(32'(regRvalid), 32'h1, "read valid");
    rdVal = regRdata;
    @(posedge core_clk);
  endtask : reg_rd

  // Polls a pending flag under a bounded count.
  task automatic wait_idle(input logic [15:0] idx);
    int n;
    for (n = 0; n < 16; n++) begin
      reg_rd(idx);
      if (rdVal[0] === 1'b0) break;
    end
    if (n == 16) begin
      error_cnt++;
      $display("CHECK FAILED at %0t: pending flag never cleared", $time);
      test_done();
    end
  endtask : wait_idle

  // Issues one priority command and waits for it to finish.
  task automatic ds_cmd(input logic dir, input logic [5:0] idx);
    reg_wr(vdta_pkg::PT_CMD_IDX, {24'h00_0000, dir, 1'b0, idx});
    wait_idle(vdta_pkg::PT_STATUS_IDX);
  endtask : ds_cmd

  // Presents a lookup index and checks the registered priority.
  task automatic lookup(input logic [5:0] idx, input logic [2:0] exp);
    tosIndex <= idx;
    @(posedge core_clk);
    @(negedge core_clk);
    chk(32'(rxPriority), 32'(exp), "lookup priority");
    @(posedge core_clk);
  endtask : lookup

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  // Reset values, read-only registers and an unmapped register number.
  task automatic t_reset();
    reg_rd(vdta_pkg::VLAN_STATUS_IDX);
    chk(rdVal, 32'h0, "vlan status reset");
    reg_rd(vdta_pkg::PT_STATUS_IDX);
    chk(rdVal, 32'h0, "table status reset");
    reg_rd(vdta_pkg::PT_CMD_IDX);
    chk(rdVal, 32'h0, "command reset");
    reg_wr(vdta_pkg::PT_STATUS_IDX, 32'hffff_ffff);
    reg_rd(vdta_pkg::PT_STATUS_IDX);
    chk(rdVal, 32'h0, "table status read only");
    reg_wr(vdta_pkg::VLAN_STATUS_IDX, 32'hffff_ffff);
    reg_rd(vdta_pkg::VLAN_STATUS_IDX);
    chk(rdVal, 32'h0, "vlan status read only");
    reg_rd(16'h1815);
    chk(rdVal, 32'h0, "unmapped read");
    $display("test reset done");
  endtask : t_reset

  // Fills every entry before any lookup, then reads every ninth by lookup and by command.
  task automatic t_table();
    for (int i = 0; i < 64; i++) begin
      reg_wr(vdta_pkg::PT_WR_IDX, {29'h0, 3'(i) ^ 3'h5});
      ds_cmd(1'b0, 6'(i));
    end
    for (int i = 0; i < 64; i += 9) begin
      lookup(6'(i), 3'(i) ^ 3'h5);
      ds_cmd(1'b1, 6'(i));
      reg_rd(vdta_pkg::PT_RD_IDX);
      chk(rdVal, {29'h0, 3'(i) ^ 3'h5}, "table read");
    end
    $display("test table done");
  endtask : t_table

  // Reserved command bits are dropped and read back as zero.
  task automatic t_fields();
    reg_wr(vdta_pkg::PT_CMD_IDX, 32'hffff_ffc9);
    wait_idle(vdta_pkg::PT_STATUS_IDX);
    reg_rd(vdta_pkg::PT_CMD_IDX);
    chk(rdVal, 32'h0000_0089, "command readback");
    reg_rd(vdta_pkg::PT_RD_IDX);
    chk(rdVal, 32'h0000_0004, "read of entry 9");
    $display("test fields done");
  endtask : t_fields

  // Status read in the cycle after a command, then a command written while pending.
  task automatic t_pending();
    reg_wr(vdta_pkg::PT_WR_IDX, 32'h0000_0007);
    regWrEn <= 1'b1;
    regIdx <= vdta_pkg::PT_CMD_IDX;
    regWdata <= 32'h0000_0011;
    @(posedge core_clk);
    regWrEn <= 1'b0;
    regRdEn <= 1'b1;
    regIdx <= vdta_pkg::PT_STATUS_IDX;
    @(posedge core_clk);
    regRdEn <= 1'b0;
    regWrEn <= 1'b1;
    regIdx <= vdta_pkg::PT_CMD_IDX;
    regWdata <= 32'h0000_0080;
    @(negedge core_clk);
    chk(regRdata, 32'h1, "pending right after command");
    @(posedge core_clk);
    regWrEn <= 1'b0;
    @(posedge core_clk);
    wait_idle(vdta_pkg::PT_STATUS_IDX);
    reg_rd(vdta_pkg::PT_CMD_IDX);
    chk(rdVal, 32'h0000_0011, "command kept");
    reg_rd(vdta_pkg::PT_RD_IDX);
    chk(rdVal, 32'h0000_0004, "refused read left data");
    lookup(6'h11, 3'h7);
    $display("test pending done");
  endtask : t_pending

  // Runs one VLAN command with a refused second start while it pends.
  task automatic vlan_cmd(input logic rd, input logic sel);
    vlanCmdStart <= 1'b1;
    vlanCmdRead <= rd;
    tableSelect <= sel;
    @(posedge core_clk);
    vlanCmdStart <= 1'b0;
    @(negedge core_clk);
    chk(32'(vlanTblReq), 32'h1, "vlan request");
    chk(32'(vlanTblReqRead), 32'(rd), "vlan direction");
    @(posedge core_clk);
    vlanCmdStart <= 1'b1;
    vlanCmdRead <= ~rd;
    @(posedge core_clk);
    vlanCmdStart <= 1'b0;
    @(negedge core_clk);
    chk(32'(vlanTblReq), 32'h0, "second start refused");
    chk(32'(vlanTblReqRead), 32'(rd), "direction kept");
    @(posedge core_clk);
    reg_rd(vdta_pkg::VLAN_STATUS_IDX);
    chk(rdVal, 32'h1, "vlan pending");
    vlanTblAck <= 1'b1;
    @(posedge core_clk);
    vlanTblAck <= 1'b0;
    @(posedge core_clk);
    reg_rd(vdta_pkg::VLAN_STATUS_IDX);
    chk(rdVal, 32'h0, "vlan pending cleared");
  endtask : vlan_cmd

  // VLAN and default-ID read words, then a write command.
  task automatic t_vlan();
    vlanEntMember <= 3'h5;
    vlanEntUntag <= 3'h3;
    vlanEntVid <= 12'h2a5;
    pvidWord <= 18'h2_3abc;
    @(posedge core_clk);
    vlan_cmd(1'b1, 1'b0);
    reg_rd(vdta_pkg::VLAN_RD_WORD_IDX);
    chk(rdVal, {14'h0, 1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 12'h2a5}, "vlan word");
    vlan_cmd(1'b1, 1'b1);
    reg_rd(vdta_pkg::VLAN_RD_WORD_IDX);
    chk(rdVal, 32'h0002_3abc, "default id word");
    vlan_cmd(1'b0, 1'b0);
    $display("test vlan done");
  endtask : t_vlan

  // Every membership pattern through the per-port forwarding outputs.
  task automatic t_fwd();
    logic [2:0] mm;
    logic [2:0] ad;
    logic [2:0] eh;
    for (int i = 0; i < 8; i++) begin
      mm = 3'(i);
      ad = {mm[0], mm[2:1]};
      eh = mm ^ 3'h6;
      matchMember <= mm;
      matchUntag <= ~mm;
      admitOutsider <= ad;
      egressHybrid <= eh;
      @(posedge core_clk);
      @(negedge core_clk);
      chk(32'(portAdmit), 32'(mm | ad), "ingress admit");
      chk(32'(egressMember), 32'(mm), "egress domain");
      chk(32'(tagStrip), 32'(~mm & eh), "tag strip");
      @(posedge core_clk);
    end
    $display("test forwarding done");
  endtask : t_fwd

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  // Holds reset for six cycles, checks quiet outputs, then runs every scenario.
  initial begin
    repeat (3) @(posedge core_clk);
    chk(32'(regRvalid), 32'h0, "valid in reset");
    chk(32'(vlanTblReq), 32'h0, "request in reset");
    repeat (3) @(posedge core_clk);
    arst_n <= 1'b1;
    @(posedge core_clk);
    t_reset();
    t_table();
    t_fields();
    t_pending();
    t_vlan();
    t_fwd();
    test_done();
  end
endmodule : vdta_table_access_tb_top
